//--- cbo_defs.svh
// Purpose: Constants for the clock/buzzer output divider
// Assumes: 8-bit processor special-function-register port, 20-bit addresses
// Notes: Addresses, field positions, write mask, reset values, clock period and counter width only
`ifndef CBO_DEFS_SVH
`define CBO_DEFS_SVH

`define CBO_ADDR_W 20
`define CBO_ADDR_SEL_CH0 20'hFFFA5
`define CBO_ADDR_SEL_CH1 20'hFFFA6
`define CBO_SEL_RESET 8'h00
`define CBO_SEL_WMASK 8'h87
`define CBO_EN_BIT 3'h7
`define CBO_CLK_PERIOD_NS 25
`define CBO_CNT_W 12

`endif

//--- cbo_pkg.sv
// Purpose: Types and shared decode for the clock/buzzer output divider
// Assumes: Included constants file is on the include path
// Notes: Half-period limit is used by the channel and its checks
`include "cbo_defs.svh"
package cbo_pkg;

   // One channel select register
   typedef struct packed {
      logic channel_output_enable;
      logic [3:0] fixed_zero;
      logic [2:0] divider_code;
   } cbo_sel_t;

   typedef enum logic [0:0] {
      CBO_IDLE = 1'b0,
      CBO_RUN = 1'b1
   } cbo_state_t;

   // Processor register port request
   typedef struct packed {
      logic [`CBO_ADDR_W-1:0] addr;
      logic byte_wr;
      logic [7:0] wdata;
      logic bit_wr;
      logic [2:0] bit_sel;
      logic bit_val;
      logic rd;
   } cbo_req_t;

   // Cycles per output half period, minus one; code 0 is not counted
   function automatic logic [`CBO_CNT_W-1:0] cbo_half_limit(input logic [2:0] code);
      case (code)
         3'h1: cbo_half_limit = 12'h000;
         3'h2: cbo_half_limit = 12'h001;
         3'h3: cbo_half_limit = 12'h003;
         3'h4: cbo_half_limit = 12'h007;
         3'h5: cbo_half_limit = 12'h3FF;
         3'h6: cbo_half_limit = 12'h7FF;
         3'h7: cbo_half_limit = 12'hFFF;
         default: cbo_half_limit = 12'h000;
      endcase
   endfunction

endpackage

//--- cbo_channel.sv
// Purpose: One divided clock/buzzer output with glitch-free start and stop
// Assumes: Divider code held steady while enabled
// Notes: Code 0 passes the main clock through a negative-edge gate
`timescale 1ns/10ps
`include "cbo_defs.svh"
module cbo_channel (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Select register fields
   input wire logic enable_in,
   input wire logic [2:0] divider_code,
   // Pin side
   output logic clock_buzzer_pin,
   output logic running
);

   typedef struct packed {
      cbo_pkg::cbo_state_t state;
      logic [`CBO_CNT_W-1:0] cnt;
      logic out;
   } cbo_chan_state_t;

   cbo_chan_state_t state_r;
   cbo_chan_state_t state_nxt;
   logic gate_r;
   logic [`CBO_CNT_W-1:0] lim;

   assign lim = cbo_pkg::cbo_half_limit(divider_code);

   always_comb begin
      state_nxt = state_r;
      case (state_r.state)
         cbo_pkg::CBO_IDLE: begin
            state_nxt.out = 1'b0;
            state_nxt.cnt = '0;
            if (enable_in) begin
               state_nxt.state = cbo_pkg::CBO_RUN;
               state_nxt.out = 1'b1;
            end
         end
         cbo_pkg::CBO_RUN: begin
            if (state_r.cnt == lim) begin
               state_nxt.cnt = '0;
               // Stop only at the end of a full low half, never mid-pulse
               if (!state_r.out && !enable_in) begin
                  state_nxt.state = cbo_pkg::CBO_IDLE;
               end else begin
                  state_nxt.out = ~state_r.out;
               end
            end else begin
               state_nxt.cnt = state_r.cnt + 12'h001;
            end
         end
         default: state_nxt = '0;
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Gate changes while the clock is low, so no partial high pulse
   always_ff @(negedge core_clk or posedge reset) begin
      if (reset) begin
         gate_r <= 1'b0;
      end else begin
         gate_r <= enable_in;
      end
   end

   assign clock_buzzer_pin = (divider_code == 3'h0) ? (core_clk & gate_r) : state_r.out;
   assign running = (state_r.state == cbo_pkg::CBO_RUN) | gate_r;

   // Helper: length of the current high half
   logic [`CBO_CNT_W:0] hi_len_r;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         hi_len_r <= '0;
      end else if (state_r.out) begin
         hi_len_r <= hi_len_r + 13'h0001;
      end else begin
         hi_len_r <= '0;
      end
   end

   sequence s_start_req;
      state_r.state == cbo_pkg::CBO_IDLE && enable_in;
   endsequence

   sequence s_half_end;
      state_r.state == cbo_pkg::CBO_RUN && state_r.cnt == lim;
   endsequence

   chk_start_one_clock: assert property (@(posedge core_clk) disable iff (reset)
      s_start_req |=> state_r.out && state_r.state == cbo_pkg::CBO_RUN)
      else $error("output did not start one clock after enable");

   chk_high_full_width: assert property (@(posedge core_clk) disable iff (reset)
      $fell(state_r.out) |-> hi_len_r == {1'b0, $past(lim)} + 13'h0001)
      else $error("shortened high pulse");

   chk_idle_low: assert property (@(posedge core_clk) disable iff (reset)
      state_r.state == cbo_pkg::CBO_IDLE |-> !state_r.out)
      else $error("output not low while disabled");

   chk_toggle_period: assert property (@(posedge core_clk) disable iff (reset)
      s_half_end ##0 (state_r.out || enable_in) |=> state_r.out != $past(state_r.out))
      else $error("output did not toggle at half period");

endmodule

//--- cbo_top.sv
// Purpose: Two clock/buzzer output channels with their select registers
// Assumes: Processor register port synchronous to core_clk (40 MHz)
// Notes: Pin multiplexing and port latch belong to the port block
//
// How it works
// - Two channels each drive their own pin, channel 0 from select register 0 and channel 1 from register 1.
// - Reset clears both select registers to zero, disabled with divider code zero.
// - Bit 7 of a select register enables its pin output when 1 and disables it when 0.
// - Divider codes 0 to 7 give the main clock divided by 1, 2, 4, 8, 16, 2048, 4096 or 8192.
// - Bits 6 to 3 of each select register always read zero and carry no function.
// - Each select register takes single-bit writes and whole-byte writes and reads back.
// - The pin starts toggling one clock after the enable bit is set; for codes 1 to 7 it stops at the end of a full low half after the bit clears.
// - Starting and stopping never produce a shortened high or low pulse.
// - Stop mode must wait at least one output period after disabling, or the last pulse is short.
`timescale 1ns/10ps
`include "cbo_defs.svh"
module cbo_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register port
   input wire logic [`CBO_ADDR_W-1:0] sfr_addr,
   input wire logic sfr_byte_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic sfr_bit_val,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // Pins
   output logic [1:0] clock_buzzer_pin,
   // Status toward the stop-mode controller
   output logic [1:0] channel_running
);

   typedef struct packed {
      cbo_pkg::cbo_sel_t clock_out_select_ch1;
      cbo_pkg::cbo_sel_t clock_out_select_ch0;
      logic [7:0] rdata;
   } cbo_top_state_t;

   cbo_top_state_t state_r;
   cbo_top_state_t state_nxt;
   cbo_pkg::cbo_req_t req;
   logic hit0;
   logic hit1;

   assign req.addr = sfr_addr;
   assign req.byte_wr = sfr_byte_wr;
   assign req.wdata = sfr_wdata;
   assign req.bit_wr = sfr_bit_wr;
   assign req.bit_sel = sfr_bit_sel;
   assign req.bit_val = sfr_bit_val;
   assign req.rd = sfr_rd;

   assign hit0 = (req.addr == `CBO_ADDR_SEL_CH0);
   assign hit1 = (req.addr == `CBO_ADDR_SEL_CH1);

   // New register value for a byte or bit write; byte write wins
   function automatic logic [7:0] cbo_write(input logic [7:0] old, input cbo_pkg::cbo_req_t r);
      logic [7:0] v;
      v = old;
      if (r.byte_wr) begin
         v = r.wdata;
      end else if (r.bit_wr) begin
         v[r.bit_sel] = r.bit_val;
      end
      cbo_write = v & `CBO_SEL_WMASK;
   endfunction

   always_comb begin
      state_nxt = state_r;
      if (hit0) begin
         state_nxt.clock_out_select_ch0 = cbo_write(state_r.clock_out_select_ch0, req);
      end
      if (hit1) begin
         state_nxt.clock_out_select_ch1 = cbo_write(state_r.clock_out_select_ch1, req);
      end
      // Read returns the value before any same-cycle write
      if (req.rd) begin
         if (hit0) begin
            state_nxt.rdata = state_r.clock_out_select_ch0;
         end else if (hit1) begin
            state_nxt.rdata = state_r.clock_out_select_ch1;
         end else begin
            state_nxt.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_r.clock_out_select_ch0 <= `CBO_SEL_RESET;
         state_r.clock_out_select_ch1 <= `CBO_SEL_RESET;
         state_r.rdata <= 8'h00;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign sfr_rdata = state_r.rdata;

   // Divider code is used live; changing it while enabled is a software fault
   cbo_channel u_ch0 (
      .core_clk(core_clk),
      .reset(reset),
      .enable_in(state_r.clock_out_select_ch0.channel_output_enable),
      .divider_code(state_r.clock_out_select_ch0.divider_code),
      .clock_buzzer_pin(clock_buzzer_pin[0]),
      .running(channel_running[0])
   );

   cbo_channel u_ch1 (
      .core_clk(core_clk),
      .reset(reset),
      .enable_in(state_r.clock_out_select_ch1.channel_output_enable),
      .divider_code(state_r.clock_out_select_ch1.divider_code),
      .clock_buzzer_pin(clock_buzzer_pin[1]),
      .running(channel_running[1])
   );

   sequence s_wr_ch0;
      hit0 && (sfr_byte_wr || sfr_bit_wr);
   endsequence

   sequence s_disabled3_ch0;
      !state_r.clock_out_select_ch0.channel_output_enable [*3];
   endsequence

   chk_reset_clears: assert property (@(posedge core_clk)
      reset |-> state_r.clock_out_select_ch0 == 8'h00 && state_r.clock_out_select_ch1 == 8'h00)
      else $error("select registers not cleared by reset");

   chk_byte_write: assert property (@(posedge core_clk) disable iff (reset)
      hit1 && sfr_byte_wr |=> state_r.clock_out_select_ch1 == ($past(sfr_wdata) & 8'h87))
      else $error("byte write not stored");

   chk_bit_write: assert property (@(posedge core_clk) disable iff (reset)
      hit0 && sfr_bit_wr && !sfr_byte_wr && sfr_bit_sel == 3'h7
      |=> state_r.clock_out_select_ch0.channel_output_enable == $past(sfr_bit_val))
      else $error("bit write to enable not stored");

   chk_fixed_zero: assert property (@(posedge core_clk) disable iff (reset)
      state_r.clock_out_select_ch0.fixed_zero == 4'h0 && state_r.clock_out_select_ch1.fixed_zero == 4'h0)
      else $error("bits 6 to 3 not zero");

   chk_read_back: assert property (@(posedge core_clk) disable iff (reset)
      sfr_rd && hit1 |=> sfr_rdata == $past(state_r.clock_out_select_ch1))
      else $error("channel 1 read data wrong");

   chk_unmapped_read: assert property (@(posedge core_clk) disable iff (reset)
      sfr_rd && !hit0 && !hit1 |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");

   chk_write_isolated: assert property (@(posedge core_clk) disable iff (reset)
      s_wr_ch0 |=> state_r.clock_out_select_ch1 == $past(state_r.clock_out_select_ch1))
      else $error("channel 0 write disturbed channel 1");

   chk_enable_starts_pin: assert property (@(posedge core_clk) disable iff (reset)
      $rose(state_r.clock_out_select_ch0.channel_output_enable) && !$past(channel_running[0])
      && state_r.clock_out_select_ch0.divider_code != 3'h0 |=> clock_buzzer_pin[0])
      else $error("enable did not start channel 0 pin");

   chk_disabled_low: assert property (@(posedge core_clk) disable iff (reset)
      s_disabled3_ch0 ##0 !channel_running[0] |-> !clock_buzzer_pin[0])
      else $error("disabled channel 0 pin not low");

endmodule

//--- cbo_pin_monitor.sv
// Purpose: Peripheral model that times the half periods on one pin
// Assumes: Pin changes on rising edges of core_clk
// Notes: Code 0 pulses are invisible at the falling edge
`timescale 1ns/10ps
module cbo_pin_monitor (
   // Clock
   core_clk,
   // Pin and clear
   pin,
   clr,
   // Completed widths in cycles
   min_w,
   max_w
);
   input wire logic core_clk;
   input wire logic pin;
   input wire logic clr;
   output logic [15:0] min_w;
   output logic [15:0] max_w;
   logic last;
   logic armed;
   logic [15:0] run;
   initial begin
      last = 1'b0;
      armed = 1'b0;
      run = 16'h0000;
      min_w = 16'hFFFF;
      max_w = 16'h0000;
   end
   // Run in progress at clear is partial, so it is never recorded
   always @(negedge core_clk) begin
      if (clr) begin
         armed = 1'b0;
         min_w = 16'hFFFF;
         max_w = 16'h0000;
      end
      if (pin !== last) begin
         if (armed && run < min_w) min_w = run;
         if (armed && run > max_w) max_w = run;
         armed = !clr;
         run = 16'h0001;
         last = pin;
      end else begin
         run = run + 16'h0001;
      end
   end
endmodule

//--- cbo_top_tb.sv
// Purpose: Self-checking bench for the clock/buzzer output divider
// Assumes: Inputs driven at the falling edge, seed 13
// Notes: Code 0 waveform is sampled mid-phase
`timescale 1ns/10ps
`include "cbo_defs.svh"
module cbo_top_tb;
   logic core_clk, reset, byte_wr, bit_wr, bit_val, rd;
   logic [19:0] addr;
   logic [7:0] wdata, rdata, d;
   logic [2:0] bit_sel, code;
   logic [1:0] pin, running, clr;
   logic [1:0][15:0] min_w, max_w;
   logic [15:0] h;
   logic [19:0] a;
   int num_errors, n_compared, seed, cyc, ch;

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   cbo_top dut_u (.core_clk(core_clk), .reset(reset), .sfr_addr(addr), .sfr_byte_wr(byte_wr),
      .sfr_wdata(wdata), .sfr_bit_wr(bit_wr), .sfr_bit_sel(bit_sel), .sfr_bit_val(bit_val),
      .sfr_rd(rd), .sfr_rdata(rdata), .clock_buzzer_pin(pin), .channel_running(running));
   // Pins watched directly; port direction and latch taken as cleared
   cbo_pin_monitor mon0 (.core_clk(core_clk), .pin(pin[0]), .clr(clr[0]), .min_w(min_w[0]),
      .max_w(max_w[0]));
   cbo_pin_monitor mon1 (.core_clk(core_clk), .pin(pin[1]), .clr(clr[1]), .min_w(min_w[1]),
      .max_w(max_w[1]));

   task end_of_test;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task wr(input logic [19:0] ad, input logic [7:0] dv);
      addr = ad;
      wdata = dv;
      byte_wr = 1'b1;
      @(negedge core_clk) byte_wr = 1'b0;
   endtask

   task bw(input logic [19:0] ad, input logic [2:0] s, input logic v);
      addr = ad;
      bit_sel = s;
      bit_val = v;
      bit_wr = 1'b1;
      @(negedge core_clk) bit_wr = 1'b0;
   endtask

   task rd_chk(input logic [19:0] ad, input logic [7:0] exp);
      addr = ad;
      rd = 1'b1;
      @(negedge core_clk) rd = 1'b0;
      chk("rdata", {8'h00, rdata}, {8'h00, exp});
   endtask

   function automatic logic [15:0] exp_half(input logic [2:0] c);
      // Code 0 halves are half a cycle; 1 keeps wait counts sane
      if (c == 3'h0)
         exp_half = 16'h0001;
      else if (c < 3'h5)
         exp_half = 16'h0001 << (int'(c) - 1);
      else
         exp_half = 16'h0001 << (int'(c) + 5);
   endfunction

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 80000) begin
         num_errors++;
         end_of_test();
      end
   end

   initial begin
      seed = 13;
      reset = 1'b1;
      {byte_wr, bit_wr, bit_val, rd} = 4'h0;
      addr = 20'h00000;
      wdata = 8'h00;
      bit_sel = 3'h0;
      clr = 2'h0;
      repeat (20) @(negedge core_clk);
      reset = 1'b0;
      rd_chk(`CBO_ADDR_SEL_CH0, 8'h00);
      @(negedge core_clk);
      rd_chk(`CBO_ADDR_SEL_CH1, 8'h00);
      chk("pins", {14'h0, pin}, 16'h0000);
      // Random contents, enable kept low so codes may change
      repeat (8) begin
         d = $random(seed);
         a = d[0] ? `CBO_ADDR_SEL_CH1 : `CBO_ADDR_SEL_CH0;
         wr(a, d & 8'h7F);
         rd_chk(a, d & 8'h07);
      end
      wr(20'hFFFA7, 8'hFF);
      rd_chk(20'hFFFA7, 8'h00);
      // Codes 0 to 2 pass 8 MHz at this clock; swept only to prove the divider
      for (int i = 0; i < 8; i++) begin
         code = i[2:0];
         ch = i % 2;
         a = ch ? `CBO_ADDR_SEL_CH1 : `CBO_ADDR_SEL_CH0;
         h = exp_half(code);
         wr(a, {5'h00, code});
         bw(a, 3'h4, 1'b1);
         rd_chk(a, {5'h00, code});
         @(posedge core_clk) clr <= 2'h3;
         @(posedge core_clk) clr <= 2'h0;
         @(negedge core_clk);
         bw(a, 3'h7, 1'b1);
         chk("pin late", {15'h0, pin[ch]}, 16'h0000);
         if (code == 3'h0) begin
            @(posedge core_clk) #5;
            chk("pin code0", {15'h0, pin[ch]}, 16'h0001);
            @(negedge core_clk);
         end else begin
            @(negedge core_clk);
            chk("pin start", {15'h0, pin[ch]}, 16'h0001);
         end
         repeat (4 * h + {$random(seed)} % (2 * h)) @(negedge core_clk);
         rd_chk(a, {1'b1, 4'h0, code});
         bw(a, 3'h7, 1'b0);
         repeat (4 * h + 4) @(negedge core_clk);
         chk("pin idle", {15'h0, pin[ch]}, 16'h0000);
         chk("running", {14'h0, running}, 16'h0000);
         chk("other pin", max_w[1 - ch], 16'h0000);
         if (code != 3'h0) begin
            chk("min half", min_w[ch], h);
            chk("max half", max_w[ch], h);
         end
      end
      // Reset in mid-run
      wr(`CBO_ADDR_SEL_CH1, 8'h05);
      bw(`CBO_ADDR_SEL_CH1, 3'h7, 1'b1);
      repeat (10) @(negedge core_clk);
      reset = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("pins reset", {14'h0, pin}, 16'h0000);
      reset = 1'b0;
      rd_chk(`CBO_ADDR_SEL_CH1, 8'h00);
      end_of_test();
   end
endmodule
